// ==== bench/daq_irq_and_input_mode_control_tb.sv ====
// self-checking bench for the interrupt and input-mode control bank
`timescale 1ns/1ps
`default_nettype none
`include "daq_ctrl_consts.svh"

module daq_irq_and_input_mode_control_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] src;
  logic [6:0] pul;
  logic ext_update_n, conv_drv, intv_drv, interval_counter_level;
  logic interval_counter_clk, ext_convert_n_out, ext_convert_n_oe_n;
  logic interval_counter_out_out, interval_counter_out_oe_n;
  logic adc_convert_start, adc_dma_request, interval_scan_tick;
  logic interval_counter_clk_tick, interval_scan_en, update_counter_flag;
  logic host_irq;
  logic [1:0] dac_update;
  daq_ctrl_pkg::input_mode_e input_mode;
  wire logic adc_data_available, adc_overflow, adc_overrun;
  wire logic port_a_irq_req, port_b_irq_req, update_counter_tick;
  wire logic timer_irq_clear, internal_convert_tick, sample_timer_tick;
  wire logic interval_counter_tick, ext_convert_n_in, interval_counter_out_in;
  wire logic [1:0] dac_high_byte_written;
  wire logic [5:0] mon;
  int cnt [6];
  int failures = 0;
  int checked = 0;

  // level sources and one-cycle pulses packed for short stimulus calls
  assign {port_b_irq_req, port_a_irq_req, adc_overrun, adc_overflow,
          adc_data_available} = src;
  assign {dac_high_byte_written, sample_timer_tick, interval_counter_tick,
          internal_convert_tick, timer_irq_clear, update_counter_tick} = pul;
  // two-way pins: the device wins while its enable is low
  assign ext_convert_n_in = ext_convert_n_oe_n ? conv_drv : ext_convert_n_out;
  assign interval_counter_out_in =
    interval_counter_out_oe_n ? intv_drv : interval_counter_out_out;
  assign mon = {~ext_convert_n_out, dac_update, interval_counter_clk_tick,
                interval_scan_tick, adc_convert_start};

  daq_irq_and_input_mode_control daq_irq_and_input_mode_control_i (.*);

  // pulse counters sampled at the edge, so comb pulses are not missed
  always @(posedge pclk) begin
    for (int i = 0; i < 6; i++) cnt[i] += 32'(mon[i]);
  end

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task summarize;
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // apb transfer, request held until pready is seen at an edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task clr;
    // off the edge, so the counting process cannot race the reset
    #1;
    for (int i = 0; i < 6; i++) cnt[i] = 0;
  endtask : clr

  // drive a pulse pattern for one cycle, then let results settle
  task pulse(input logic [6:0] v);
    @(posedge pclk) pul <= v;
    @(posedge pclk) pul <= 7'h00;
    repeat (3) @(posedge pclk);
    #1;
  endtask : pulse

  // falling then rising edge on the convert pin, slow enough to sync
  task conv_fall;
    @(posedge pclk) conv_drv <= 1'b0;
    repeat (5) @(posedge pclk);
    conv_drv <= 1'b1;
    repeat (5) @(posedge pclk);
    #1;
  endtask : conv_fall

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    #1 chk("oe_n", 32'h2,
           {30'h0, ext_convert_n_oe_n, interval_counter_out_oe_n});
    xfer(1'b0, `ADDR_INTERRUPT_DMA_ENABLE, 32'h0);
    chk("rd_irq_en", 32'h0, q);
    xfer(1'b0, `ADDR_BLOCK_STATE, 32'h0);
    chk("state", 32'h1, q);
    xfer(1'b0, 8'h7c, 32'h0);
    chk("slverr", 32'h1, 32'(err));
  endtask : t_reset

  task irq_case(input logic [7:0] en, input logic [4:0] s,
                input logic [1:0] e);
    xfer(1'b1, `ADDR_INTERRUPT_DMA_ENABLE, {24'h0, en});
    @(posedge pclk) src <= s;
    @(posedge pclk) #1 chk("irq_dma", {30'h0, e},
                           {30'h0, host_irq, adc_dma_request});
    @(posedge pclk) src <= 5'h00;
  endtask : irq_case

  // sticky update event bit: raises the line, reads back, clears by write
  task t_event;
    xfer(1'b1, `ADDR_EVENT_CLEAR, 32'h1f);
    xfer(1'b1, `ADDR_EVENT_ENABLE, 32'h04);
    pulse(7'h01);
    chk("ev_irq", 32'h1, 32'(host_irq));
    xfer(1'b0, `ADDR_EVENT_STATUS, 32'h0);
    chk("ev_stat", 32'h4, q);
    xfer(1'b1, `ADDR_EVENT_CLEAR, 32'h04);
    #1 chk("ev_clr", 32'h0, 32'(host_irq));
    xfer(1'b1, `ADDR_EVENT_ENABLE, 32'h0);
  endtask : t_event

  task t_counter;
    xfer(1'b1, `ADDR_INTERRUPT_DMA_ENABLE, 32'h08);
    xfer(1'b1, `ADDR_AUX_CONFIG, 32'h02);
    clr;
    pulse(7'h01);
    chk("flag_irq", 32'h3, {30'h0, update_counter_flag, host_irq});
    pulse(7'h60);
    chk("dac0", 32'h1, cnt[3]);
    chk("dac1", 32'h1, cnt[4]);
    pulse(7'h02);
    chk("flag_clr", 32'h0, {30'h0, update_counter_flag, host_irq});
    @(posedge pclk) ext_update_n <= 1'b0;
    repeat (6) @(posedge pclk);
    ext_update_n <= 1'b1;
    #1 chk("ext_upd", 32'h3, {30'h0, update_counter_flag, host_irq});
    chk("dac0_ext", 32'h2, cnt[3]);
    pulse(7'h02);
  endtask : t_counter

  task t_convert;
    clr;
    conv_fall;
    chk("pin_conv", 32'h1, cnt[0]);
    xfer(1'b1, `ADDR_INPUT_MODE_SCAN_CONTROL, 32'h10);
    clr;
    conv_fall;
    chk("pin_ignored", 32'h0, cnt[0]);
    xfer(1'b1, `ADDR_INPUT_MODE_SCAN_CONTROL, 32'h04);
    clr;
    pulse(7'h04);
    chk("drive_oe_n", 32'h0, 32'(ext_convert_n_oe_n));
    chk("int_conv", 32'h1, cnt[0]);
    chk("pin_pulse", 32'h1, cnt[5]);
  endtask : t_convert

  task mode_case(input logic [7:0] d, input logic [7:0] nr,
                 input logic [2:0] e);
    xfer(1'b1, `ADDR_INPUT_MODE_SCAN_CONTROL, {24'h0, d});
    xfer(1'b1, `ADDR_AUX_CONFIG, {24'h0, nr});
    @(posedge pclk) #1 chk("mode", {29'h0, e}, {29'h0, input_mode});
  endtask : mode_case

  task t_interval;
    xfer(1'b1, `ADDR_INPUT_MODE_SCAN_CONTROL, 32'h00);
    @(posedge pclk) interval_counter_level <= 1'b1;
    clr;
    pulse(7'h08);
    chk("ivl_out", 32'h1, {31'h0, interval_counter_out_out});
    chk("ivl_tick", 32'h1, cnt[1]);
    xfer(1'b1, `ADDR_INPUT_MODE_SCAN_CONTROL, 32'h02);
    clr;
    pulse(7'h08);
    @(posedge pclk) intv_drv <= 1'b1;
    repeat (5) @(posedge pclk);
    #1 chk("ivl_rx_oe_n", 32'h1, 32'(interval_counter_out_oe_n));
    chk("ivl_rx_tick", 32'h1, cnt[1]);
  endtask : t_interval

  // one sample-timer tick and one connector clock edge; only one counts
  task clk_case(input logic [7:0] d);
    xfer(1'b1, `ADDR_INPUT_MODE_SCAN_CONTROL, {24'h0, d});
    clr;
    pulse(7'h10);
    @(posedge pclk) interval_counter_clk <= 1'b1;
    repeat (5) @(posedge pclk);
    interval_counter_clk <= 1'b0;
    repeat (5) @(posedge pclk);
    #1 chk("clk_tick", 32'h1, cnt[2]);
    chk("scan_en", {31'h0, d[0]}, 32'(interval_scan_en));
  endtask : clk_case

  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    failures++;
    summarize;
  end

  initial begin
    {presetn, psel, penable, pwrite, ext_update_n, conv_drv} = 6'h03;
    {intv_drv, interval_counter_level, interval_counter_clk} = 3'h0;
    {paddr, pwdata, src, pul} = '0;
    conv_drv = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    irq_case(8'h20, 5'h01, 2'b10);
    irq_case(8'h10, 5'h02, 2'b10);
    irq_case(8'h10, 5'h04, 2'b10);
    irq_case(8'h02, 5'h08, 2'b10);
    irq_case(8'h02, 5'h10, 2'b10);
    irq_case(8'h01, 5'h01, 2'b01);
    irq_case(8'h00, 5'h1f, 2'b00);
    t_event;
    t_counter;
    t_convert;
    mode_case(8'h00, 8'h00, 3'b001);
    mode_case(8'h00, 8'h01, 3'b010);
    mode_case(8'h08, 8'h00, 3'b100);
    mode_case(8'h08, 8'h01, 3'b100);
    t_interval;
    clk_case(8'h01);
    clk_case(8'h00);
    summarize;
  end
endmodule : daq_irq_and_input_mode_control_tb

`default_nettype wire

// ==== core/daq_ctrl_consts.svh ====
// register offsets, field positions and reset values of the control bank
`ifndef DAQ_CTRL_CONSTS_SVH
`define DAQ_CTRL_CONSTS_SVH

// ****************************************************************
// register indices and byte addresses (byte address = 4 * index)
// ****************************************************************
`define IDX_INTERRUPT_DMA_ENABLE    8'h02
`define IDX_INPUT_MODE_SCAN_CONTROL 8'h0f
`define ADDR_INTERRUPT_DMA_ENABLE   8'h08
`define ADDR_INPUT_MODE_SCAN_CONTROL 8'h3c
`define ADDR_EVENT_STATUS           8'h40
`define ADDR_EVENT_CLEAR            8'h44
`define ADDR_EVENT_ENABLE           8'h48
`define ADDR_AUX_CONFIG             8'h4c
`define ADDR_BLOCK_STATE            8'h50

// ****************************************************************
// interrupt_dma_enable fields
// ****************************************************************
`define BIT_DATA_READY_IRQ_EN    5
`define BIT_ADC_ERROR_IRQ_EN     4
`define BIT_UPDATE_COUNTER_IRQ_EN 3
`define BIT_DIGITAL_PORT_IRQ_EN  1
`define BIT_ADC_DMA_REQUEST_EN   0
`define MASK_INTERRUPT_DMA_ENABLE 8'h3b

// ****************************************************************
// input_mode_scan_control fields
// ****************************************************************
`define BIT_EXT_CONVERT_RX_DISABLE 4
`define BIT_DIFFERENTIAL_SEL       3
`define BIT_CONVERT_PULSE_DRIVE    2
`define BIT_INTERVAL_CLOCK_RX      1
`define BIT_INTERVAL_SCAN_EN       0
`define MASK_INPUT_MODE_SCAN_CONTROL 8'h1f

// ****************************************************************
// aux_config fields, event bits, reset values
// ****************************************************************
`define BIT_NONREFERENCED_SEL 0
`define BIT_DAC0_TIMED_LOAD   1
`define BIT_DAC1_TIMED_LOAD   2
`define MASK_AUX_CONFIG       8'h07
`define EVENT_COUNT           5
`define EV_DATA_READY         0
`define EV_ADC_ERROR          1
`define EV_UPDATE             2
`define EV_DIGITAL_PORT       3
`define EV_CONVERT            4
`define RESET_CMD_REG         8'h00
`define RESET_EVENT_REG       5'h00

`endif

// ==== core/daq_ctrl_pkg.sv ====
// types shared by the control bank
package daq_ctrl_pkg;

  // analog input mode, one-hot
  typedef enum logic [2:0] {
    MODE_REFERENCED_SINGLE_ENDED    = 3'b001,
    MODE_NONREFERENCED_SINGLE_ENDED = 3'b010,
    MODE_DIFFERENTIAL               = 3'b100
  } input_mode_e;

endpackage : daq_ctrl_pkg

// ==== core/daq_irq_and_input_mode_control.sv ====
// interrupt/dma enable and input-mode/scan control bank behind apb
//
// Notes on behaviour
// - data-ready enable set interrupts while adc data available is set.
// - error enable set interrupts on adc overflow or overrun.
// - counter enable set interrupts on the update counter flag.
// - the same update event sets the flag and loads timed dacs.
// - digital port enable passes port a/b requests, else blocks them from all but the event log.
// - dma enable set requests dma while data is available.
// - rx-disable or drive bit set ignores convert pin; else falling edge starts conversion.
// - differential and nonreferenced bits select one of three modes.
// - drive bit clear after reset; set drives convert pulses out.
// - interval rx clear clocks scan from counter and drives its pin.
// - interval rx set makes the pin an input clocking the scan.
// - interval scan on: counter clocked by sample timer, else connector.
// - timed dac loads on update event, else on high byte write.
//
// Added by the designer: register access over APB.
`include "daq_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module daq_irq_and_input_mode_control (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // acquisition sources, same clock
  input  wire logic        adc_data_available,
  input  wire logic        adc_overflow,
  input  wire logic        adc_overrun,
  input  wire logic        update_counter_tick,
  input  wire logic        timer_irq_clear,
  input  wire logic        port_a_irq_req,
  input  wire logic        port_b_irq_req,
  input  wire logic        internal_convert_tick,
  input  wire logic        sample_timer_tick,
  input  wire logic        interval_counter_tick,
  input  wire logic        interval_counter_level,
  input  wire logic [1:0]  dac_high_byte_written,
  // connector pins
  input  wire logic        ext_update_n,
  input  wire logic        ext_convert_n_in,
  output logic             ext_convert_n_out,
  output logic             ext_convert_n_oe_n,
  input  wire logic        interval_counter_out_in,
  output logic             interval_counter_out_out,
  output logic             interval_counter_out_oe_n,
  input  wire logic        interval_counter_clk,
  // results to the acquisition logic
  output logic             adc_convert_start,
  output logic             adc_dma_request,
  output logic             interval_scan_tick,
  output logic             interval_counter_clk_tick,
  output logic             interval_scan_en,
  output daq_ctrl_pkg::input_mode_e input_mode,
  output logic [1:0]       dac_update,
  output logic             update_counter_flag,
  output logic             host_irq
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  interrupt_dma_enable_reg;
  logic [7:0]  input_mode_scan_control_reg;
  logic [7:0]  aux_config_reg;
  logic [4:0]  event_enable_reg;
  logic [31:0] prdata_reg;
  logic        slverr_reg;
  logic        update_counter_flag_reg;
  logic [1:0]  dac_update_reg;
  logic        convert_start_reg;
  logic        ext_convert_out_reg;
  logic        interval_pin_out_reg;

  logic [3:0]  pin_rise;
  logic [3:0]  pin_fall;
  logic [4:0]  event_status;
  logic        event_irq_out;
  logic [4:0]  event_pulse;
  logic        wr_access;
  logic        setup_phase;
  logic        update_event;
  logic        ext_start;
  logic        data_prev_reg;
  logic        err_prev_reg;
  logic        dio_prev_reg;
  logic        doc_irq;

  // address match, used by write decode and read mux
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a[7:2] == r[7:2]);
  endfunction : hit

  function automatic logic known(input logic [7:0] a);
    known = hit(a, `ADDR_INTERRUPT_DMA_ENABLE)
          | hit(a, `ADDR_INPUT_MODE_SCAN_CONTROL)
          | hit(a, `ADDR_EVENT_STATUS) | hit(a, `ADDR_EVENT_CLEAR)
          | hit(a, `ADDR_EVENT_ENABLE) | hit(a, `ADDR_AUX_CONFIG)
          | hit(a, `ADDR_BLOCK_STATE);
  endfunction : known

  // ****************************************************************
  // apb slave: one wait-free access phase
  // ****************************************************************
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite;
  assign pready      = 1'b1;
  assign prdata      = prdata_reg;
  assign pslverr     = psel & penable & slverr_reg;

  // read data captured in setup so it comes from a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (setup_phase) begin
      slverr_reg <= ~known(paddr);
      prdata_reg <= 32'h0000_0000;
      if (!pwrite) begin
        // command registers are write-only and read back zero
        if (hit(paddr, `ADDR_EVENT_STATUS))
          prdata_reg <= {27'h0, event_status};
        else if (hit(paddr, `ADDR_EVENT_ENABLE))
          prdata_reg <= {27'h0, event_enable_reg};
        else if (hit(paddr, `ADDR_AUX_CONFIG))
          prdata_reg <= {24'h0, aux_config_reg};
        else if (hit(paddr, `ADDR_BLOCK_STATE))
          prdata_reg <= {26'h0, host_irq, adc_dma_request,
                         update_counter_flag_reg, input_mode};
      end
    end
  end

  // command registers, unused bits dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_dma_enable_reg    <= `RESET_CMD_REG;
      input_mode_scan_control_reg <= `RESET_CMD_REG;
    end else if (wr_access) begin
      if (hit(paddr, `ADDR_INTERRUPT_DMA_ENABLE))
        interrupt_dma_enable_reg <= pwdata[7:0]
                                    & `MASK_INTERRUPT_DMA_ENABLE;
      if (hit(paddr, `ADDR_INPUT_MODE_SCAN_CONTROL))
        input_mode_scan_control_reg <= pwdata[7:0]
                                       & `MASK_INPUT_MODE_SCAN_CONTROL;
    end
  end

  // auxiliary configuration and event enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_config_reg   <= `RESET_CMD_REG;
      event_enable_reg <= `RESET_EVENT_REG;
    end else if (wr_access) begin
      if (hit(paddr, `ADDR_AUX_CONFIG))
        aux_config_reg <= pwdata[7:0] & `MASK_AUX_CONFIG;
      if (hit(paddr, `ADDR_EVENT_ENABLE))
        event_enable_reg <= pwdata[4:0];
    end
  end

  // ****************************************************************
  // connector pin synchronisers
  // ****************************************************************
  pin_sync #(
    .W (4)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({interval_counter_clk, interval_counter_out_in,
               ext_update_n, ext_convert_n_in}),
    .level   (),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // ****************************************************************
  // input mode and conversion start
  // ****************************************************************
  // differential wins over the nonreferenced bit
  always_comb begin
    if (input_mode_scan_control_reg[`BIT_DIFFERENTIAL_SEL])
      input_mode = daq_ctrl_pkg::MODE_DIFFERENTIAL;
    else if (aux_config_reg[`BIT_NONREFERENCED_SEL])
      input_mode = daq_ctrl_pkg::MODE_NONREFERENCED_SINGLE_ENDED;
    else
      input_mode = daq_ctrl_pkg::MODE_REFERENCED_SINGLE_ENDED;
  end

  // a falling pin edge counts only when neither disabled nor driven
  assign ext_start = pin_fall[0]
    & ~input_mode_scan_control_reg[`BIT_EXT_CONVERT_RX_DISABLE]
    & ~input_mode_scan_control_reg[`BIT_CONVERT_PULSE_DRIVE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      convert_start_reg   <= 1'b0;
      ext_convert_out_reg <= 1'b1;
    end else begin
      convert_start_reg <= ext_start | (internal_convert_tick
        & input_mode_scan_control_reg[`BIT_CONVERT_PULSE_DRIVE]);
      ext_convert_out_reg <= ~internal_convert_tick;
    end
  end

  assign adc_convert_start  = convert_start_reg;
  assign ext_convert_n_out  = ext_convert_out_reg;
  assign ext_convert_n_oe_n =
    ~input_mode_scan_control_reg[`BIT_CONVERT_PULSE_DRIVE];

  // ****************************************************************
  // interval scan clocking
  // ****************************************************************
  assign interval_scan_en =
    input_mode_scan_control_reg[`BIT_INTERVAL_SCAN_EN];
  assign interval_scan_tick =
    input_mode_scan_control_reg[`BIT_INTERVAL_CLOCK_RX]
      ? pin_rise[2] : interval_counter_tick;
  assign interval_counter_clk_tick =
    interval_scan_en ? sample_timer_tick : pin_rise[3];
  assign interval_counter_out_oe_n =
    input_mode_scan_control_reg[`BIT_INTERVAL_CLOCK_RX];

  // pin copy of the counter output, registered for a clean drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      interval_pin_out_reg <= 1'b0;
    else
      interval_pin_out_reg <= interval_counter_level;
  end
  assign interval_counter_out_out = interval_pin_out_reg;

  // ****************************************************************
  // update event: counter flag and dac loads
  // ****************************************************************
  assign update_event = update_counter_tick | pin_fall[1];

  // set wins over the timer clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      update_counter_flag_reg <= 1'b0;
    else if (update_event)
      update_counter_flag_reg <= 1'b1;
    else if (timer_irq_clear)
      update_counter_flag_reg <= 1'b0;
  end
  assign update_counter_flag = update_counter_flag_reg;

  // timed dacs follow the update event, others the high byte write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_update_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        dac_update_reg[i] <= aux_config_reg[`BIT_DAC0_TIMED_LOAD + i]
          ? update_event : dac_high_byte_written[i];
      end
    end
  end
  assign dac_update = dac_update_reg;

  // ****************************************************************
  // interrupts and dma
  // ****************************************************************
  assign adc_dma_request = adc_data_available
    & interrupt_dma_enable_reg[`BIT_ADC_DMA_REQUEST_EN];

  // levels: each stays until its own source is serviced
  assign doc_irq =
    (adc_data_available
      & interrupt_dma_enable_reg[`BIT_DATA_READY_IRQ_EN])
    | ((adc_overflow | adc_overrun)
      & interrupt_dma_enable_reg[`BIT_ADC_ERROR_IRQ_EN])
    | (update_counter_flag_reg
      & interrupt_dma_enable_reg[`BIT_UPDATE_COUNTER_IRQ_EN])
    | ((port_a_irq_req | port_b_irq_req)
      & interrupt_dma_enable_reg[`BIT_DIGITAL_PORT_IRQ_EN]);

  // rising edges of the source levels feed the event log
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_prev_reg <= 1'b0;
      err_prev_reg  <= 1'b0;
      dio_prev_reg  <= 1'b0;
    end else begin
      data_prev_reg <= adc_data_available;
      err_prev_reg  <= adc_overflow | adc_overrun;
      dio_prev_reg  <= port_a_irq_req | port_b_irq_req;
    end
  end

  assign event_pulse[`EV_DATA_READY]   = adc_data_available & ~data_prev_reg;
  assign event_pulse[`EV_ADC_ERROR]    =
    (adc_overflow | adc_overrun) & ~err_prev_reg;
  assign event_pulse[`EV_UPDATE]       = update_event;
  assign event_pulse[`EV_DIGITAL_PORT] =
    (port_a_irq_req | port_b_irq_req) & ~dio_prev_reg;
  assign event_pulse[`EV_CONVERT]      = convert_start_reg;

  event_irq #(
    .N (`EVENT_COUNT)
  ) u_event_irq (
    .pclk        (pclk),
    .presetn     (presetn),
    .event_pulse (event_pulse),
    .clear_wr    (wr_access & hit(paddr, `ADDR_EVENT_CLEAR)),
    .clear_bits  (pwdata[4:0]),
    .enable_bits (event_enable_reg),
    .status      (event_status),
    .irq         (event_irq_out)
  );

  assign host_irq = doc_irq | event_irq_out;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_data_irq;
    @(posedge pclk) disable iff (!presetn)
    (adc_data_available && interrupt_dma_enable_reg[5]) |-> host_irq;
  endproperty
  a_data_irq: assert property (p_data_irq)
    else $error("data ready did not raise interrupt");

  property p_err_irq;
    @(posedge pclk) disable iff (!presetn)
    ((adc_overflow || adc_overrun) && interrupt_dma_enable_reg[4])
      |-> host_irq;
  endproperty
  a_err_irq: assert property (p_err_irq)
    else $error("adc error did not raise interrupt");

  property p_cnt_flag;
    @(posedge pclk) disable iff (!presetn)
    update_event |=> update_counter_flag_reg
      && (interrupt_dma_enable_reg[3] -> host_irq);
  endproperty
  a_cnt_flag: assert property (p_cnt_flag)
    else $error("update event lost");

  property p_dac_timed;
    @(posedge pclk) disable iff (!presetn)
    (update_event && aux_config_reg[1] && !$past(wr_access))
      |=> dac_update_reg[0];
  endproperty
  a_dac_timed: assert property (p_dac_timed)
    else $error("timed dac missed update event");

  property p_dio_block;
    @(posedge pclk) disable iff (!presetn)
    (!interrupt_dma_enable_reg[1] && !interrupt_dma_enable_reg[5]
      && !interrupt_dma_enable_reg[4] && !interrupt_dma_enable_reg[3]
      && event_irq_out == 1'b0) |-> !host_irq;
  endproperty
  a_dio_block: assert property (p_dio_block)
    else $error("interrupt raised with all sources disabled");

  property p_dma;
    @(posedge pclk) disable iff (!presetn)
    adc_dma_request == (adc_data_available && interrupt_dma_enable_reg[0]);
  endproperty
  a_dma: assert property (p_dma)
    else $error("dma request mismatch");

  property p_ext_conv;
    @(posedge pclk) disable iff (!presetn)
    (pin_fall[0] && input_mode_scan_control_reg[4:2] == 3'b000)
      |=> adc_convert_start;
  endproperty
  a_ext_conv: assert property (p_ext_conv)
    else $error("falling convert edge did not start conversion");

  property p_mode;
    @(posedge pclk) disable iff (!presetn)
    input_mode_scan_control_reg[3]
      |-> input_mode == daq_ctrl_pkg::MODE_DIFFERENTIAL;
  endproperty
  a_mode: assert property (p_mode)
    else $error("differential mode not selected");

  property p_pin_dir;
    @(posedge pclk) disable iff (!presetn)
    interval_counter_out_oe_n == input_mode_scan_control_reg[1]
      && ext_convert_n_oe_n == !input_mode_scan_control_reg[2];
  endproperty
  a_pin_dir: assert property (p_pin_dir)
    else $error("pin direction wrong");

  property p_reset_zero;
    @(posedge pclk) $rose(presetn) |-> interrupt_dma_enable_reg == 8'h00
      && input_mode_scan_control_reg == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("command register not zero after reset");

  c_ext_conv: cover property (@(posedge pclk) disable iff (!presetn)
    ext_start ##1 adc_convert_start);
  c_cnt_irq: cover property (@(posedge pclk) disable iff (!presetn)
    update_event && interrupt_dma_enable_reg[3] ##1 host_irq);
  c_rx_scan: cover property (@(posedge pclk) disable iff (!presetn)
    input_mode_scan_control_reg[1] && interval_scan_tick);

endmodule : daq_irq_and_input_mode_control

`default_nettype wire

// ==== core/event_irq.sv ====
// sticky event status with enable, clear-on-write and level interrupt
`timescale 1ns/1ps
`default_nettype none

module event_irq #(
  parameter int N = 5
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // event pulses
  input  wire logic [N-1:0] event_pulse,
  // software side
  input  wire logic         clear_wr,
  input  wire logic [N-1:0] clear_bits,
  input  wire logic [N-1:0] enable_bits,
  // status and interrupt
  output logic      [N-1:0] status,
  output logic              irq
);

  logic [N-1:0] status_reg;

  // set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~(clear_wr ? clear_bits : '0))
                    | event_pulse;
    end
  end

  assign status = status_reg;
  assign irq    = |(status_reg & enable_bits);

endmodule : event_irq

`default_nettype wire

// ==== core/pin_sync.sv ====
// two-flop synchronisers for connector pins with edge pulses
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // raw pins
  input  wire logic [W-1:0] pin_in,
  // synchronised level and edges
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // idle high: all pins here are active-low or idle-high clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '1;
      sync_reg <= '1;
      prev_reg <= '1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // edge pulses look only at the second stage onward
  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;

endmodule : pin_sync

`default_nettype wire
